// ===== core/cfag_unit.sv
// flag update and effective address generation of an 8-bit core
// assumes single clock, alu results and decoded modes arrive from the core
//
// The address map and the strobed register port were chosen for this implementation.
`include "cfag_consts.svh"
`default_nettype none
module cfag_unit (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire cfag_pkg::cfag_alu_s i_alu,
	input wire logic i_set_mask,
	input wire logic i_clr_mask,
	input wire logic i_irq_req,
	input wire cfag_pkg::cfag_addr_s i_addr,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic [7:0] o_flags,
	output logic o_irq_take,
	output cfag_pkg::cfag_addr_out_s o_addr
);
	import cfag_pkg::*;

	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [15:0] ea_last;
	logic [15:0] pc_last;
	cfag_mode_e mode_last;
	logic [7:0] rdata;

	// result byte or word views
	wire logic [15:0] res_w = i_alu.word ? i_alu.result : {8'h00, i_alu.result[7:0]};
	wire logic msb = i_alu.word ? i_alu.result[15] : i_alu.result[7];
	wire logic is_zero = (res_w == 16'h0000);
	wire logic cin = i_alu.carry_in_use & flags[`CFAG_BIT_C];

	// byte adder and subtractor with carry chain
	wire logic [8:0] add9 = {1'b0, i_alu.a[7:0]} + {1'b0, i_alu.b[7:0]} + {8'h00, cin};
	wire logic [8:0] sub9 = {1'b0, i_alu.a[7:0]} - {1'b0, i_alu.b[7:0]} - {8'h00, cin};
	wire logic [4:0] half = {1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]} + {4'h0, cin};
	wire logic is_add = (i_alu.op == op_add) | (i_alu.op == op_adc);
	wire logic is_sub = (i_alu.op == op_sub);
	wire logic add_ovf = (i_alu.a[7] == i_alu.b[7]) & (add9[7] != i_alu.a[7]);
	wire logic sub_ovf = (i_alu.a[7] != i_alu.b[7]) & (sub9[7] != i_alu.a[7]);

	// flag values chosen by operation class
	wire logic carry_next = is_add ? add9[8] : is_sub ? sub9[8] : i_alu.shift_carry;
	wire logic ovf_next = is_add ? add_ovf : is_sub ? sub_ovf : 1'b0;
	wire logic flags_wr = i_reg_wr && (i_reg_addr == `CFAG_OFS_FLAGS);

	always_comb begin
		next_flags = flags;
		if (i_alu.valid && i_alu.op != op_none) begin
			next_flags[`CFAG_BIT_N] = msb;
			next_flags[`CFAG_BIT_Z] = is_zero;
			case (i_alu.op)
				op_add: begin
					next_flags[`CFAG_BIT_C] = carry_next;
					next_flags[`CFAG_BIT_H] = half[4];
					next_flags[`CFAG_BIT_V] = ovf_next;
				end

				op_adc: begin
					next_flags[`CFAG_BIT_C] = carry_next;
					next_flags[`CFAG_BIT_H] = half[4];
					next_flags[`CFAG_BIT_V] = ovf_next;
				end

				op_sub: begin
					next_flags[`CFAG_BIT_C] = carry_next;
					next_flags[`CFAG_BIT_V] = ovf_next;
				end

				op_shift: begin
					next_flags[`CFAG_BIT_C] = carry_next;
				end

				op_load: begin
					next_flags[`CFAG_BIT_V] = ovf_next;
				end

				op_logic: begin
					next_flags[`CFAG_BIT_V] = ovf_next;
				end

				default: begin
					next_flags = flags;
				end
			endcase
		end
		if (i_set_mask) begin
			next_flags[`CFAG_BIT_I] = 1'b1;
		end else if (i_clr_mask) begin
			next_flags[`CFAG_BIT_I] = 1'b0;
		end
		if (flags_wr) begin
			next_flags = i_reg_wdata;
		end
		next_flags = next_flags | `CFAG_FLAGS_ONES;
	end

	// committed at the completing edge, seen by the next instruction
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			flags <= `CFAG_FLAGS_RESET;
		end else if (i_ce) begin
			flags <= next_flags;
		end
	end

	assign o_flags = flags;
	assign o_irq_take = i_irq_req & ~flags[`CFAG_BIT_I];

	// address generation is combinational, then registered into o_addr at the next edge
	wire logic [15:0] rel_ofs = {{8{i_addr.operand[7]}}, i_addr.operand[7:0]};
	wire logic [15:0] zx8 = {8'h00, i_addr.operand[7:0]};
	wire logic [15:0] pc_taken = 16'(i_addr.pc + rel_ofs);
	wire logic [15:0] sum8 = 16'(i_addr.base + zx8);
	wire logic [15:0] sum16 = 16'(i_addr.base + i_addr.operand);
	logic [15:0] ea;
	logic mem;
	logic [15:0] lit;

	always_comb begin
		ea = 16'h0000;
		mem = 1'b1;
		lit = 16'h0000;
		case (i_addr.mode)
			// operands in core registers only
			register_only_mode: begin
				ea = 16'h0000;
				mem = 1'b0;
				lit = 16'h0000;
			end

			// operand bytes follow the opcode
			literal_operand_mode: begin
				ea = i_addr.pc;
				mem = 1'b0;
				lit = i_addr.wide ? i_addr.operand : zx8;
			end

			// branch target from signed offset
			pc_offset_mode: begin
				ea = pc_taken;
				mem = 1'b0;
				lit = 16'h0000;
			end

			// zero page from the operand byte
			direct_mode: begin
				ea = zx8;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// full address in the operand word
			extended_mode: begin
				ea = i_addr.operand;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// index pair as the address
			ix_mode: begin
				ea = i_addr.base;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// index pair, incremented later by the core
			ix_inc_mode: begin
				ea = i_addr.base;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// index pair plus unsigned byte
			ix1_mode: begin
				ea = sum8;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// index pair plus byte, then increment
			ix1_inc_mode: begin
				ea = sum8;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// index pair plus unsigned word
			ix2_mode: begin
				ea = sum16;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// stack pointer plus unsigned byte
			sp1_mode: begin
				ea = sum8;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// stack pointer plus unsigned word
			sp2_mode: begin
				ea = sum16;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// source in zero page
			dd_mode: begin
				ea = zx8;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// literal source, zero page destination
			id_mode: begin
				ea = zx8;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// source at index pair
			ixd_mode: begin
				ea = i_addr.base;
				mem = 1'b1;
				lit = 16'h0000;
			end

			// source in zero page, destination at index pair
			dix_mode: begin
				ea = zx8;
				mem = 1'b1;
				lit = 16'h0000;
			end

			default: begin
				ea = 16'h0000;
				mem = 1'b1;
				lit = 16'h0000;
			end
		endcase
	end

	// test-and-branch reuses the relative target beside the operand address
	wire logic [15:0] next_pc_w = i_addr.take_branch ? pc_taken : i_addr.pc;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_addr.ea <= 16'h0000;
			o_addr.literal <= 16'h0000;
			o_addr.mem_access <= 1'b0;
			o_addr.next_pc <= 16'h0000;
		end else if (i_ce && i_addr.valid) begin
			o_addr.ea <= ea;
			o_addr.literal <= lit;
			o_addr.mem_access <= mem;
			o_addr.next_pc <= next_pc_w;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ea_last <= 16'h0000;
			pc_last <= 16'h0000;
			mode_last <= register_only_mode;
		end else if (i_ce && i_addr.valid) begin
			ea_last <= ea;
			pc_last <= next_pc_w;
			mode_last <= i_addr.mode;
		end
	end

	// register read port
	always_comb begin
		case (i_reg_addr)
			`CFAG_OFS_FLAGS: begin
				rdata = flags;
			end

			`CFAG_OFS_PC_LO: begin
				rdata = pc_last[7:0];
			end

			`CFAG_OFS_PC_HI: begin
				rdata = pc_last[15:8];
			end

			`CFAG_OFS_EA_LO: begin
				rdata = ea_last[7:0];
			end

			`CFAG_OFS_EA_HI: begin
				rdata = ea_last[15:8];
			end

			`CFAG_OFS_MODE: begin
				rdata = {4'h0, mode_last};
			end

			default: begin
				rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata <= 8'h00;
		end else if (i_ce) begin
			o_reg_rdata <= i_reg_rd ? rdata : 8'h00;
		end
	end
endmodule : cfag_unit
`default_nettype wire

// ===== inc/cfag_consts.svh
// constants for the flag and address unit
// assumes a 10 MHz core clock and a plain register port
`ifndef CFAG_CONSTS_SVH
`define CFAG_CONSTS_SVH
`define CFAG_BIT_C 0
`define CFAG_BIT_Z 1
`define CFAG_BIT_N 2
`define CFAG_BIT_I 3
`define CFAG_BIT_H 4
`define CFAG_BIT_V 7
`define CFAG_FLAGS_RESET 8'h68
`define CFAG_FLAGS_ONES 8'h60
`define CFAG_OFS_FLAGS 4'h0
`define CFAG_OFS_PC_LO 4'h1
`define CFAG_OFS_PC_HI 4'h2
`define CFAG_OFS_EA_LO 4'h3
`define CFAG_OFS_EA_HI 4'h4
`define CFAG_OFS_MODE 4'h5
`define CFAG_MODE_COUNT 16
`endif

// ===== inc/cfag_pkg.sv
// types for the flag and address unit
// assumes cfag_consts.svh is on the include path
`default_nettype none
package cfag_pkg;
	typedef enum logic [3:0] {
		register_only_mode, literal_operand_mode, pc_offset_mode, direct_mode,
		extended_mode, ix_mode, ix_inc_mode, ix1_mode, ix1_inc_mode, ix2_mode,
		sp1_mode, sp2_mode, dd_mode, id_mode, ixd_mode, dix_mode
	} cfag_mode_e;
	typedef enum logic [2:0] {
		op_none, op_load, op_add, op_adc, op_sub, op_logic, op_shift
	} cfag_op_e;
	typedef struct packed {
		logic valid;
		cfag_op_e op;
		logic word;
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] result;
		logic carry_in_use;
		logic shift_carry;
	} cfag_alu_s;
	typedef struct packed {
		logic valid;
		cfag_mode_e mode;
		logic [15:0] pc;
		logic [15:0] base;
		logic [15:0] operand;
		logic wide;
		logic take_branch;
	} cfag_addr_s;
	typedef struct packed {
		logic [15:0] ea;
		logic [15:0] literal;
		logic mem_access;
		logic [15:0] next_pc;
	} cfag_addr_out_s;
endpackage : cfag_pkg
`default_nettype wire

// ===== test/cfag_unit_assertions.sv
// port checker for the flag and address unit
// assumes it is bound onto cfag_unit
`default_nettype none
module cfag_unit_chk (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire cfag_pkg::cfag_alu_s i_alu,
	input wire logic i_reg_wr,
	input wire logic i_irq_req,
	input wire cfag_pkg::cfag_addr_s i_addr,
	input wire logic [7:0] o_flags,
	input wire logic o_irq_take,
	input wire cfag_pkg::cfag_addr_out_s o_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	import cfag_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	wire a_ok = i_ce && i_alu.valid && !i_alu.word && !i_reg_wr && i_alu.op != op_none;
	wire b_ok = i_ce && i_addr.valid;
	wire br = b_ok && i_addr.mode == pc_offset_mode;
	neg_flag_a: assert property (a_ok |=> o_flags[2] == $past(i_alu.result[7]))
		else $error("negative flag wrong");
	zero_flag_a: assert property (a_ok |=> o_flags[1] == ($past(i_alu.result[7:0]) == 8'h00))
		else $error("zero flag wrong");
	fixed_ones_a: assert property (o_flags[6:5] == 2'b11)
		else $error("bits 6 and 5 not one");
	irq_gate_a: assert property (o_irq_take == (i_irq_req && !o_flags[3]))
		else $error("interrupt gating wrong");
	branch_taken_a: assert property (br && i_addr.take_branch |=>
		o_addr.next_pc == $past(i_addr.pc) + {{8{$past(i_addr.operand[7])}}, $past(i_addr.operand[7:0])})
		else $error("taken branch target wrong");
	branch_plain_a: assert property (br && !i_addr.take_branch |=> o_addr.next_pc == $past(i_addr.pc))
		else $error("untaken branch moved");
	inh_no_mem_a: assert property (b_ok && i_addr.mode == register_only_mode |=> !o_addr.mem_access)
		else $error("inherent mode accessed memory");
	literal_value_a: assert property (b_ok && i_addr.mode == literal_operand_mode && i_addr.wide
		|=> o_addr.literal == $past(i_addr.operand))
		else $error("literal operand wrong");
	cover property (br && i_addr.take_branch);
	cover property (a_ok ##1 a_ok);
	cover property (o_irq_take);
endmodule : cfag_unit_chk
`default_nettype wire

// ===== test/cfag_mem_model.sv
// memory and peripheral space model on the effective address
// assumes ea and mem_access from cfag_unit
`default_nettype none
module cfag_mem_model (
	input wire logic i_clk_sys,
	input wire cfag_pkg::cfag_addr_out_s i_bus,
	output logic [7:0] o_data = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge i_clk_sys) begin
		if (i_bus.mem_access) begin
			o_data <= i_bus.ea[15:8] ^ i_bus.ea[7:0];
		end else begin
			o_data <= ~o_data;
		end
	end
endmodule : cfag_mem_model
`default_nettype wire

// ===== test/cfag_unit_tb.sv
// testbench for the flag and address unit
// assumes the package, unit, model and checker are compiled first
`default_nettype none
module cfag_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cfag_pkg::*;
	logic clk = 0, rstn = 0, ce = 1, smask = 0, cmask = 0, irq = 0, wr = 0, rd = 0, irqt;
	logic [3:0] ra = 0;
	logic [7:0] wd = 0, rdat, flags, md, a, b;
	logic [8:0] s;
	logic [1:0] vh;
	logic [15:0] pw, bw, vw;
	logic [39:0] rx;
	cfag_alu_s alu = '0;
	cfag_addr_s ad = '0;
	cfag_addr_out_s ao;
	int fail_count = 0, check_count = 0, seed = 12922, i;
	always #50 clk = ~clk;
	cfag_unit cfag_unit_i (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_alu(alu),
		.i_set_mask(smask), .i_clr_mask(cmask), .i_irq_req(irq), .i_addr(ad), .i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_flags(flags),
		.o_irq_take(irqt), .o_addr(ao));
	cfag_mem_model cfag_mem_model_i (.i_clk_sys(clk), .i_bus(ao), .o_data(md));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [1:0] exp_vh(input int k, input logic [7:0] x, y, r,
		input logic [1:0] old);
		logic [4:0] h;
		h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
		if (k == 0)
			exp_vh = {x[7] == y[7] && r[7] != x[7], h[4]};
		else if (k == 1)
			exp_vh = {x[7] != y[7] && r[7] != x[7], old[0]};
		else
			exp_vh = old;
	endfunction : exp_vh
	function automatic logic [15:0] exp_ea(input int m, input logic [15:0] p, x, v);
		case (m)
			0: exp_ea = 16'h0000;
			1: exp_ea = p;
			2: exp_ea = 16'(p + {{8{v[7]}}, v[7:0]});
			3, 12, 13, 15: exp_ea = {8'h00, v[7:0]};
			4: exp_ea = v;
			5, 6, 14: exp_ea = x;
			7, 8, 10: exp_ea = 16'(x + {8'h00, v[7:0]});
			default: exp_ea = 16'(x + v);
		endcase
	endfunction : exp_ea
	task automatic go;
		@(posedge clk);
		alu.valid <= 0;
		ad.valid <= 0;
		{wr, rd, smask, cmask} <= 4'h0;
		#1;
	endtask : go
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	initial begin
		#100us;
		fail_count++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1;
		go;
		rd <= 1; ra <= 4'h0; go; chk(rdat, 8'h68);
		rd <= 1; ra <= 4'hF; go; chk(rdat, 8'h00);
		wr <= 1; wd <= 8'h00; ra <= 4'h0; go; chk(flags, 8'h60);
		irq <= 1; go; chk(irqt, 1'b1);
		smask <= 1; go; chk({irqt, flags[3]}, 2'b01);
		cmask <= 1; go; chk(irqt, 1'b1);
		vh = 2'b00;
		for (i = 0; i < 30; i++) begin
			a = i ? 8'($random(seed)) : 8'h80;
			b = i ? 8'($random(seed)) : 8'h80;
			s = i % 3 == 0 ? a + b : i % 3 == 1 ? a - b : {a, 1'b0};
			alu <= '{1'b1, i % 3 == 0 ? op_add : i % 3 == 1 ? op_sub : op_shift, 1'b0,
				{8'h00, a}, {8'h00, b}, {8'h00, s[7:0]}, 1'b0, a[7]};
			go;
			chk(flags[2:0], {s[7], s[7:0] == 8'h00, s[8]});
			vh = exp_vh(i % 3, a, b, s[7:0], vh);
			chk({flags[7], flags[4]}, vh);
		end
		for (i = 0; i < 2; i++) begin
			alu <= '{1'b1, op_load, 1'b1, 16'h0, 16'h0, i ? 16'h8000 : 16'h0000, 1'b0, 1'b0};
			go;
			chk(flags[2:1], i ? 2'b10 : 2'b01);
		end
		ce <= 0;
		alu <= '{1'b1, op_load, 1'b1, 16'h0, 16'h0, 16'h0000, 1'b0, 1'b0};
		go;
		chk(flags[2:1], 2'b10);
		ce <= 1;
		for (i = 0; i < 20; i++) begin
			a = i ? 8'($random(seed)) : 8'h80;
			ad <= '{1'b1, pc_offset_mode, 16'h0010, 16'h0, {8'h00, a}, 1'b0, !i[0]};
			go;
			chk(ao.next_pc, i[0] ? 16'h0010 : 16'h0010 + {{8{a[7]}}, a});
		end
		for (i = 0; i < 16; i++) begin
			pw = 16'($random(seed));
			bw = 16'($random(seed));
			vw = 16'($random(seed));
			ad <= '{1'b1, cfag_mode_e'(i), pw, bw, vw, 1'b1, 1'b0};
			go;
			chk(ao.mem_access, {15'h0000, i > 2});
			chk(ao.ea, exp_ea(i, pw, bw, vw));
			if (i == 1) chk(ao.literal, vw);
		end
		rx = {8'h0F, 8'h00, vw[7:0], pw[15:8], pw[7:0]};
		for (i = 1; i < 6; i++) begin
			rd <= 1;
			ra <= 4'(i);
			go;
			chk(rdat, rx[8 * i - 8 +: 8]);
		end
		chk(md, vw[7:0]);
		ad <= '{1'b1, literal_operand_mode, pw, bw, vw, 1'b0, 1'b0};
		go;
		chk(ao.literal, {8'h00, vw[7:0]});
		ad <= '{1'b1, direct_mode, 16'h1000, 16'h0000, 16'h00FE, 1'b0, 1'b1};
		go;
		chk(ao.next_pc, 16'h0FFE);
		chk(ao.ea, 16'h00FE);
		rstn <= 0;
		go;
		chk(flags, 8'h68);
		chk(ao.next_pc, 16'h0000);
		rstn <= 1;
		go;
		chk(flags, 8'h68);
		finish_test;
	end
endmodule : cfag_unit_tb
bind cfag_unit cfag_unit_chk cfag_unit_chk_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
	.i_alu(i_alu), .i_reg_wr(i_reg_wr), .i_irq_req(i_irq_req), .i_addr(i_addr),
	.o_flags(o_flags), .o_irq_take(o_irq_take), .o_addr(o_addr));
`default_nettype wire
